// ---- shared/tss_pkg.sv ----
package tss_pkg;
// What this block does
// RL1 - Send Hello after hello timeout silence
// RL2 - Controller request names target channel identifier
// RL3 - Reply carries our chosen session identifier
// RL4 - Reply reports configuration, changeability, capabilities
// RL5 - Controller disconnects on unacceptable reply values
// RL6 - Connected message carries only wanted changes
// RL7 - Acknowledge acceptable connect, else disconnect
// RL8 - Forward data only after connect processed
// RL9 - Discard session data while configuring
// RL10 - Sessions only on an established connection
// RL11 - Controller initiates; modulator accepts requests
// RL12 - One disconnect tears one session down
// RL13 - One stop closes connection and sessions
// RL14 - Controller sends link info on changes
// RL15 - Modulator sends link info on changes
// RL16 - Request carries allocation, MTU, sync attributes
// RL17 - Reply carries allocation, MTU, capabilities, channel
// RL18 - Mandatory attributes always present

   // Register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_LOCAL_SID = 12'h008;
   localparam logic [11:0] OFS_TRANSPORT_STREAM_ID = 12'h00c;
   localparam logic [11:0] OFS_FREQ = 12'h010;
   localparam logic [11:0] OFS_SYMRATE = 12'h014;
   localparam logic [11:0] OFS_POWER = 12'h018;
   localparam logic [11:0] OFS_MISC = 12'h01c;
   localparam logic [11:0] OFS_CHANGEABLE = 12'h020;
   localparam logic [11:0] OFS_CAPS = 12'h024;
   localparam logic [11:0] OFS_UDP_MTU = 12'h028;
   localparam logic [11:0] OFS_REMOTE_SID = 12'h02c;

   // Control register bits
   localparam int CTRL_CC_UP = 0;
   localparam int CTRL_CMD_CDN = 1;
   localparam int CTRL_CMD_STOP = 2;

   // Reset values
   localparam logic [31:0] RST_LOCAL_SID = 32'h0000_0001;
   localparam logic [6:0] RST_CHANGEABLE = 7'h7f;
   localparam logic [31:0] RST_UDP_MTU = 32'h0000_05dc;

   // Message type codes
   localparam logic [7:0] MSG_STOPCCN = 8'h04;
   localparam logic [7:0] MSG_HELLO = 8'h06;
   localparam logic [7:0] MSG_ICRQ = 8'h0a;
   localparam logic [7:0] MSG_ICRP = 8'h0b;
   localparam logic [7:0] MSG_ICCN = 8'h0c;
   localparam logic [7:0] MSG_CDN = 8'h0e;
   localparam logic [7:0] MSG_SLI = 8'h10;
   localparam logic [7:0] MSG_ACK = 8'h14;

   // Attribute presence mask, one bit per attribute except the channel group, which has seven
   localparam logic [15:0] AT_RES_ALLOC = 16'h0001;
   localparam logic [15:0] AT_MTU = 16'h0002;
   localparam logic [15:0] AT_SYNC = 16'h0004;
   localparam logic [15:0] AT_UDP_PORT = 16'h0008;
   localparam logic [15:0] AT_CAPS = 16'h0010;
   localparam logic [15:0] AT_CHAN = 16'h0fe0;
   localparam logic [15:0] AT_TRANSPORT_STREAM_ID_GROUP = 16'h1000;
   localparam logic [15:0] AT_RESULT = 16'h2000;
   localparam logic [15:0] AT_TARGET_CHAN = 16'h4000;
   localparam logic [15:0] AT_REMOTE_SESS = 16'h8000;
   localparam int AT_CHAN_LSB = 5;
   // Channel bits: freq, power, modulation, annex, symbol rate, interleaver, silence
   localparam int CH_FREQ = 0;
   localparam int CH_POWER = 1;
   localparam int CH_MOD = 2;
   localparam int CH_ANNEX = 3;
   localparam int CH_SYMRATE = 4;
   localparam int CH_INTLV = 5;
   localparam int CH_SILENCE = 6;
   // Misc word fields
   localparam int MISC_MOD_LSB = 0;
   localparam int MISC_ANNEX_LSB = 4;
   localparam int MISC_INTLV_LSB = 8;
   localparam int MISC_SILENCE = 15;
   localparam logic [15:0] ICRQ_NEED = 16'h4007;
   localparam logic [15:0] ICRP_MASK = 16'h8ff3;

   // Result codes for disconnects
   localparam logic [15:0] RC_MISSING_ATTR = 16'h0001;
   localparam logic [15:0] RC_BAD_TRANSPORT_STREAM_ID = 16'h0002;
   localparam logic [15:0] RC_BUSY = 16'h0003;
   localparam logic [15:0] RC_PARAM_REJECT = 16'h0004;
   localparam logic [15:0] RC_ADMIN = 16'h0005;

   // Pending message slots, higher index sent first
   localparam int P_HELLO = 0;
   localparam int P_SLI = 1;
   localparam int P_ACK = 2;
   localparam int P_ICRP = 3;
   localparam int P_CDN = 4;
   localparam int P_STOP = 5;

   // Keep-alive timing
   localparam longint unsigned CLK_HZ = 50_000_000;
   localparam longint unsigned HELLO_TIMEOUT_S = 60;
   localparam longint unsigned HELLO_CYCLES = HELLO_TIMEOUT_S * CLK_HZ;

   typedef enum logic [1:0] {S_IDLE, S_READY, S_WAIT, S_ACTIVE} tss_sess_state_t;
endpackage

// ---- logic/tss_keepalive.sv ----
`timescale 1ns/100ps
module tss_keepalive (
   input wire logic clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic activity,
   input wire logic [31:0] limit,
   output logic hello_req
);
   typedef struct packed {
      logic [31:0] cnt;
      logic req;
   } tss_ka_state_t;

   tss_ka_state_t q;
   tss_ka_state_t d;

   // Silence counter; any traffic from the peer restarts it
   always_comb begin
      d = q;
      d.req = 1'b0;
      if (!enable || activity) begin
         d.cnt = 32'h0;
      end else if (q.cnt >= limit - 32'h1) begin
         d.cnt = 32'h0; // RL1
         d.req = 1'b1; // RL1
      end else begin
         d.cnt = q.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign hello_req = q.req;
endmodule

// ---- logic/tss_modulator_sig.sv ----
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
module tss_modulator_sig #(
   parameter logic [31:0] HELLO_CYCLES = 32'(tss_pkg::HELLO_CYCLES)
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_msg_valid,
   output logic rx_msg_ready,
   input wire logic [7:0] rx_msg_type,
   input wire logic [15:0] rx_attr_mask,
   input wire logic [31:0] rx_session_id,
   input wire logic [15:0] rx_transport_stream_id,
   input wire logic [31:0] rx_freq,
   input wire logic [31:0] rx_symrate,
   input wire logic [15:0] rx_power,
   input wire logic [15:0] rx_misc,
   output logic tx_msg_valid,
   input wire logic tx_msg_ready,
   output logic [7:0] tx_msg_type,
   output logic [15:0] tx_attr_mask,
   output logic [31:0] tx_session_id,
   output logic [31:0] tx_local_session,
   output logic [15:0] tx_result_code,
   output logic [31:0] tx_freq,
   output logic [31:0] tx_symrate,
   output logic [15:0] tx_power,
   output logic [15:0] tx_misc,
   output logic [6:0] tx_changeable,
   output logic [31:0] tx_caps,
   output logic [31:0] tx_udp_mtu,
   input wire logic data_in_valid,
   output logic data_in_ready,
   input wire logic [7:0] data_in,
   output logic data_out_valid,
   output logic [7:0] data_out
);
   typedef struct packed {
      tss_pkg::tss_sess_state_t st;
      logic cc_up;
      logic [31:0] lsid;
      logic [15:0] transport_stream_id;
      logic [31:0] freq;
      logic [31:0] symr;
      logic [15:0] pwr;
      logic [15:0] misc;
      logic [6:0] chg;
      logic [31:0] caps;
      logic [31:0] udp_mtu;
      logic [31:0] rsid;
      logic [31:0] cdn_sid;
      logic [5:0] pend;
      logic [15:0] res;
      logic [15:0] last_res;
      logic [31:0] prdata;
      logic [7:0] dout;
      logic dout_v;
      logic out_v;
      logic [7:0] out_type;
      logic [15:0] out_mask;
      logic [31:0] out_sid;
   } tss_sig_state_t;

   tss_sig_state_t q;
   tss_sig_state_t d;
   logic hello_req;
   logic rx_fire;
   logic apb_wr;
   logic [6:0] req_chg;

   // Address decode, used by the write enable and the error answer
   function automatic logic reg_hit(input logic [11:0] a);
      reg_hit = (a[1:0] == 2'b00) && (a <= tss_pkg::OFS_REMOTE_SID);
   endfunction

   // Highest-priority pending slot
   function automatic logic [2:0] pick(input logic [5:0] p);
      pick = 3'h0;
      for (int i = 0; i < 6; i++) begin
         if (p[i]) begin
            pick = 3'(i);
         end
      end
   endfunction

   function automatic logic [7:0] type_of(input logic [2:0] i);
      case (i)
         3'h5: type_of = tss_pkg::MSG_STOPCCN;
         3'h4: type_of = tss_pkg::MSG_CDN;
         3'h3: type_of = tss_pkg::MSG_ICRP;
         3'h2: type_of = tss_pkg::MSG_ACK;
         3'h1: type_of = tss_pkg::MSG_SLI;
         default: type_of = tss_pkg::MSG_HELLO;
      endcase
   endfunction

   function automatic logic [15:0] mask_of(input logic [2:0] i);
      case (i)
         3'h5, 3'h4: mask_of = tss_pkg::AT_RESULT; // RL18
         3'h3: mask_of = tss_pkg::ICRP_MASK; // RL17
         3'h1: mask_of = tss_pkg::AT_CHAN; // RL15
         default: mask_of = 16'h0;
      endcase
   endfunction

   assign rx_fire = rx_msg_valid;
   assign apb_wr = psel && penable && pwrite && reg_hit(paddr);
   assign req_chg = rx_attr_mask[tss_pkg::AT_CHAN_LSB +: 7];

   tss_keepalive u_keepalive (
      .clk(clk),
      .nrst(nrst),
      .enable(q.cc_up),
      .activity(rx_fire || data_in_valid),
      .limit(HELLO_CYCLES),
      .hello_req(hello_req)
   );

   // Next state: data gate, output slot, received messages, then software
   always_comb begin
      logic [2:0] sel;
      logic [6:0] upd;
      sel = pick(q.pend);
      upd = 7'h0;
      d = q;
      d.dout_v = 1'b0; // RL9
      // Payload only flows once the session runs; anything earlier is dropped
      if (data_in_valid && q.st == tss_pkg::S_ACTIVE) begin
         d.dout_v = 1'b1; // RL8
         d.dout = data_in;
      end
      // Output slot; clears come first so that later sets win
      if (q.out_v && tx_msg_ready) begin
         d.out_v = 1'b0;
      end
      if (!q.out_v && |q.pend) begin
         d.out_v = 1'b1;
         d.pend[sel] = 1'b0;
         d.out_type = type_of(sel);
         d.out_mask = mask_of(sel);
         d.out_sid = (sel == 3'(tss_pkg::P_CDN)) ? q.cdn_sid : q.rsid;
      end
      if (hello_req) begin
         d.pend[tss_pkg::P_HELLO] = 1'b1; // RL1
      end
      // Received control messages
      if (rx_fire && q.cc_up) begin
         case (rx_msg_type)
            tss_pkg::MSG_HELLO: begin
               d.pend[tss_pkg::P_ACK] = 1'b1;
            end
            tss_pkg::MSG_ICRQ: begin
               d.cdn_sid = rx_session_id;
               if (q.st != tss_pkg::S_READY) begin
                  d.res = tss_pkg::RC_BUSY; // RL10
                  d.pend[tss_pkg::P_CDN] = 1'b1;
               end else if ((rx_attr_mask & tss_pkg::ICRQ_NEED) != tss_pkg::ICRQ_NEED) begin
                  d.res = tss_pkg::RC_MISSING_ATTR; // RL18
                  d.pend[tss_pkg::P_CDN] = 1'b1;
               end else if (rx_transport_stream_id != q.transport_stream_id) begin
                  d.res = tss_pkg::RC_BAD_TRANSPORT_STREAM_ID; // RL2
                  d.pend[tss_pkg::P_CDN] = 1'b1;
               end else begin
                  d.rsid = rx_session_id; // RL11
                  d.pend[tss_pkg::P_ICRP] = 1'b1; // RL3
                  d.st = tss_pkg::S_WAIT;
               end
            end
            tss_pkg::MSG_ICCN: begin
               if (q.st == tss_pkg::S_WAIT) begin
                  if ((req_chg & ~q.chg) != 7'h0) begin
                     d.res = tss_pkg::RC_PARAM_REJECT; // RL7
                     d.cdn_sid = q.rsid;
                     d.pend[tss_pkg::P_CDN] = 1'b1;
                     d.st = tss_pkg::S_READY;
                  end else begin
                     upd = req_chg; // RL6
                     d.pend[tss_pkg::P_ACK] = 1'b1; // RL7
                     d.st = tss_pkg::S_ACTIVE; // RL8
                  end
               end
            end
            tss_pkg::MSG_SLI: begin
               if (q.st == tss_pkg::S_WAIT || q.st == tss_pkg::S_ACTIVE) begin
                  upd = req_chg & q.chg; // RL14
                  d.pend[tss_pkg::P_ACK] = 1'b1;
               end
            end
            tss_pkg::MSG_CDN: begin
               if (q.st == tss_pkg::S_WAIT || q.st == tss_pkg::S_ACTIVE) begin
                  d.st = tss_pkg::S_READY; // RL12
               end
               d.pend[tss_pkg::P_ACK] = 1'b1;
            end
            tss_pkg::MSG_STOPCCN: begin
               d.cc_up = 1'b0; // RL13
               d.st = tss_pkg::S_IDLE; // RL13
               d.pend = 6'h0;
               d.pend[tss_pkg::P_ACK] = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // Apply accepted channel changes field by field
      if (upd[tss_pkg::CH_FREQ]) begin
         d.freq = rx_freq;
      end
      if (upd[tss_pkg::CH_POWER]) begin
         d.pwr = rx_power;
      end
      if (upd[tss_pkg::CH_SYMRATE]) begin
         d.symr = rx_symrate;
      end
      if (upd[tss_pkg::CH_MOD]) begin
         d.misc[tss_pkg::MISC_MOD_LSB +: 4] = rx_misc[tss_pkg::MISC_MOD_LSB +: 4];
      end
      if (upd[tss_pkg::CH_ANNEX]) begin
         d.misc[tss_pkg::MISC_ANNEX_LSB +: 4] = rx_misc[tss_pkg::MISC_ANNEX_LSB +: 4];
      end
      if (upd[tss_pkg::CH_INTLV]) begin
         d.misc[tss_pkg::MISC_INTLV_LSB +: 4] = rx_misc[tss_pkg::MISC_INTLV_LSB +: 4];
      end
      if (upd[tss_pkg::CH_SILENCE]) begin
         d.misc[tss_pkg::MISC_SILENCE] = rx_misc[tss_pkg::MISC_SILENCE];
      end
      if (q.pend[tss_pkg::P_CDN] || q.pend[tss_pkg::P_STOP]) begin
         d.last_res = q.res;
      end
      // APB read data is captured in the setup cycle, so the access phase needs no wait
      if (psel && !penable && !pwrite) begin
         case (paddr)
            tss_pkg::OFS_CTRL: d.prdata = {31'h0, q.cc_up};
            tss_pkg::OFS_STATUS: d.prdata = {q.last_res, 14'h0, q.st};
            tss_pkg::OFS_LOCAL_SID: d.prdata = q.lsid;
            tss_pkg::OFS_TRANSPORT_STREAM_ID: d.prdata = {16'h0, q.transport_stream_id};
            tss_pkg::OFS_FREQ: d.prdata = q.freq;
            tss_pkg::OFS_SYMRATE: d.prdata = q.symr;
            tss_pkg::OFS_POWER: d.prdata = {16'h0, q.pwr};
            tss_pkg::OFS_MISC: d.prdata = {16'h0, q.misc};
            tss_pkg::OFS_CHANGEABLE: d.prdata = {25'h0, q.chg};
            tss_pkg::OFS_CAPS: d.prdata = q.caps;
            tss_pkg::OFS_UDP_MTU: d.prdata = q.udp_mtu;
            tss_pkg::OFS_REMOTE_SID: d.prdata = q.rsid;
            default: d.prdata = 32'h0;
         endcase
      end
      // Software writes; channel edits while a session runs are announced to the peer
      if (apb_wr) begin
         case (paddr)
            tss_pkg::OFS_CTRL: begin
               d.cc_up = pwdata[tss_pkg::CTRL_CC_UP];
               if (!pwdata[tss_pkg::CTRL_CC_UP]) begin
                  d.st = tss_pkg::S_IDLE;
               end else if (q.st == tss_pkg::S_IDLE) begin
                  d.st = tss_pkg::S_READY; // RL10
               end
               if (pwdata[tss_pkg::CTRL_CMD_STOP] && q.cc_up) begin
                  d.res = tss_pkg::RC_ADMIN;
                  d.pend[tss_pkg::P_STOP] = 1'b1; // RL13
                  d.cc_up = 1'b0;
                  d.st = tss_pkg::S_IDLE;
               end else if (pwdata[tss_pkg::CTRL_CMD_CDN] &&
                            (q.st == tss_pkg::S_WAIT || q.st == tss_pkg::S_ACTIVE)) begin
                  d.res = tss_pkg::RC_ADMIN;
                  d.cdn_sid = q.rsid;
                  d.pend[tss_pkg::P_CDN] = 1'b1; // RL12
                  d.st = tss_pkg::S_READY;
               end
            end
            tss_pkg::OFS_LOCAL_SID: d.lsid = pwdata;
            tss_pkg::OFS_TRANSPORT_STREAM_ID: d.transport_stream_id = pwdata[15:0];
            tss_pkg::OFS_FREQ: d.freq = pwdata;
            tss_pkg::OFS_SYMRATE: d.symr = pwdata;
            tss_pkg::OFS_POWER: d.pwr = pwdata[15:0];
            tss_pkg::OFS_MISC: d.misc = pwdata[15:0];
            tss_pkg::OFS_CHANGEABLE: d.chg = pwdata[6:0];
            tss_pkg::OFS_CAPS: d.caps = pwdata;
            tss_pkg::OFS_UDP_MTU: d.udp_mtu = pwdata;
            default: begin
            end
         endcase
         if (q.st == tss_pkg::S_ACTIVE && (paddr == tss_pkg::OFS_FREQ ||
             paddr == tss_pkg::OFS_SYMRATE || paddr == tss_pkg::OFS_POWER ||
             paddr == tss_pkg::OFS_MISC)) begin
            d.pend[tss_pkg::P_SLI] = 1'b1; // RL15
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '0;
         q.lsid <= tss_pkg::RST_LOCAL_SID;
         q.chg <= tss_pkg::RST_CHANGEABLE;
         q.udp_mtu <= tss_pkg::RST_UDP_MTU;
      end else begin
         q <= d;
      end
   end

   // Zero-wait APB slave; unmapped or unaligned addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !reg_hit(paddr);
   assign prdata = q.prdata;
   assign rx_msg_ready = 1'b1;
   assign data_in_ready = 1'b1; // Discarded rather than held, so never stalls
   assign data_out_valid = q.dout_v;
   assign data_out = q.dout;
   assign tx_msg_valid = q.out_v;
   assign tx_msg_type = q.out_type;
   assign tx_attr_mask = q.out_mask;
   assign tx_session_id = q.out_sid;
   assign tx_local_session = q.lsid; // RL3
   assign tx_result_code = q.last_res;
   assign tx_freq = q.freq; // RL4
   assign tx_symrate = q.symr;
   assign tx_power = q.pwr;
   assign tx_misc = q.misc;
   assign tx_changeable = q.chg; // RL4
   assign tx_caps = q.caps;
   assign tx_udp_mtu = q.udp_mtu;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_hello_gated;
      hello_req |-> $past(q.cc_up);
   endproperty
   a_hello_gated: assert property (p_hello_gated) else $error("hello without connection"); // RL1

   property p_icrp_shape;
      q.out_v && q.out_type == tss_pkg::MSG_ICRP |->
         q.out_mask == tss_pkg::ICRP_MASK && tx_local_session == q.lsid;
   endproperty
   a_icrp_shape: assert property (p_icrp_shape) else $error("reply attributes wrong"); // RL17

   property p_data_only_active;
      data_out_valid |-> $past(q.st) == tss_pkg::S_ACTIVE;
   endproperty
   a_data_only_active: assert property (p_data_only_active) else $error("early data"); // RL8

   property p_drop_while_config;
      data_in_valid && q.st == tss_pkg::S_WAIT |=> !data_out_valid;
   endproperty
   a_drop_while_config: assert property (p_drop_while_config) else $error("data kept"); // RL9

   property p_iccn_reject;
      rx_fire && q.cc_up && rx_msg_type == tss_pkg::MSG_ICCN && q.st == tss_pkg::S_WAIT &&
         (req_chg & ~q.chg) != 7'h0 && !apb_wr |=>
         q.pend[tss_pkg::P_CDN] && q.st == tss_pkg::S_READY;
   endproperty
   a_iccn_reject: assert property (p_iccn_reject) else $error("bad connect not refused"); // RL7

   property p_iccn_accept;
      rx_fire && q.cc_up && rx_msg_type == tss_pkg::MSG_ICCN && q.st == tss_pkg::S_WAIT &&
         (req_chg & ~q.chg) == 7'h0 && !apb_wr |=>
         q.pend[tss_pkg::P_ACK] && q.st == tss_pkg::S_ACTIVE;
   endproperty
   a_iccn_accept: assert property (p_iccn_accept) else $error("good connect not acked"); // RL7

   property p_stop_clears;
      rx_fire && q.cc_up && rx_msg_type == tss_pkg::MSG_STOPCCN && !apb_wr |=>
         q.st == tss_pkg::S_IDLE && !q.cc_up ##1 !data_out_valid;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("stop left session up"); // RL13

   property p_sli_on_change;
      apb_wr && paddr == tss_pkg::OFS_FREQ && q.st == tss_pkg::S_ACTIVE |=>
         q.pend[tss_pkg::P_SLI] || (q.out_v && q.out_type == tss_pkg::MSG_SLI);
   endproperty
   a_sli_on_change: assert property (p_sli_on_change) else $error("change not announced"); // RL15

   property p_no_session_idle;
      rx_fire && !q.cc_up && rx_msg_type == tss_pkg::MSG_ICRQ && !apb_wr |=>
         q.st == tss_pkg::S_IDLE;
   endproperty
   a_no_session_idle: assert property (p_no_session_idle) else $error("session w/o link"); // RL10

   property p_missing_attr;
      rx_fire && q.cc_up && q.st == tss_pkg::S_READY && rx_msg_type == tss_pkg::MSG_ICRQ &&
         (rx_attr_mask & tss_pkg::ICRQ_NEED) != tss_pkg::ICRQ_NEED && !apb_wr |=>
         q.pend[tss_pkg::P_CDN] && q.st == tss_pkg::S_READY;
   endproperty
   a_missing_attr: assert property (p_missing_attr) else $error("bad request taken"); // RL18

   c_session_up: cover property (q.st == tss_pkg::S_WAIT ##[1:20] q.st == tss_pkg::S_ACTIVE);
   c_hello_sent: cover property (q.out_v && q.out_type == tss_pkg::MSG_HELLO && tx_msg_ready);
   c_reject: cover property (q.st == tss_pkg::S_WAIT ##1 q.pend[tss_pkg::P_CDN]);
endmodule

// ---- tb/tss_peer.sv ----
`timescale 1ns/100ps
// Core controller stand-in: starts the session exchanges, sinks every message the modulator sends
module tss_peer (
   input wire logic clk,
   output logic rx_msg_valid,
   output logic [7:0] rx_msg_type,
   output logic [15:0] rx_attr_mask,
   output logic [31:0] rx_session_id,
   output logic [15:0] rx_transport_stream_id,
   output logic [31:0] rx_freq,
   input wire logic tx_msg_valid,
   output logic tx_msg_ready,
   input wire logic [7:0] tx_msg_type,
   input wire logic [15:0] tx_attr_mask,
   input wire logic [31:0] tx_session_id,
   input wire logic [15:0] tx_result_code
);
   logic stall = 1'b0;
   logic [7:0] got_type;
   logic [15:0] got_mask;
   logic [15:0] got_rc;
   logic [31:0] got_sid;
   int n_got = 0;

   initial {rx_msg_valid, rx_msg_type, rx_attr_mask, rx_session_id, tx_msg_ready} = '0;
   initial {rx_transport_stream_id, rx_freq} = '0;

   // Sink; a stall models a slow controller, never a lost reply
   always @(posedge clk) begin
      tx_msg_ready <= !stall;
      if (tx_msg_valid && tx_msg_ready) begin
         got_type <= tx_msg_type;
         got_mask <= tx_attr_mask;
         got_sid <= tx_session_id;
         got_rc <= tx_result_code;
         n_got <= n_got + 1;
      end
   end

   // One-cycle message; fields inverted afterwards so stale values never pass
   task send(input logic [7:0] t, input logic [15:0] m, input logic [15:0] ts,
             input logic [31:0] f);
      @(posedge clk);
      rx_msg_valid <= 1'b1;
      rx_msg_type <= t;
      rx_attr_mask <= m;
      rx_session_id <= 32'h0000_1234;
      rx_transport_stream_id <= ts;
      rx_freq <= f;
      @(posedge clk);
      rx_msg_valid <= 1'b0;
      rx_msg_type <= ~t;
      rx_attr_mask <= ~m;
      rx_session_id <= 32'hffff_edcb;
      rx_transport_stream_id <= ~ts;
      rx_freq <= ~f;
   endtask
endmodule

// ---- tb/tss_modulator_sig_test.sv ----
`timescale 1ns/100ps
module tss_modulator_sig_test;
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, rx_session_id, rx_freq, tx_session_id;
   logic [31:0] tx_local_session;
   logic pready, pslverr, err, rx_msg_valid, rx_msg_ready, tx_msg_valid, tx_msg_ready;
   logic [7:0] rx_msg_type, tx_msg_type, data_in = 8'h00, data_out;
   logic [15:0] rx_attr_mask, rx_transport_stream_id, tx_attr_mask, tx_result_code;
   logic data_in_valid = 1'b0, data_in_ready, data_out_valid;
   int miscompares = 0, compares = 0, cyc = 0;

   // Short keep-alive so the idle wait stays brief
   tss_modulator_sig #(.HELLO_CYCLES(32'd300)) dut_u (.clk, .nrst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_msg_valid, .rx_msg_ready,
      .rx_msg_type, .rx_attr_mask, .rx_session_id, .rx_transport_stream_id, .rx_freq,
      .rx_symrate(32'h0000_0000), .rx_power(16'h0000), .rx_misc(16'h0000), .tx_msg_valid,
      .tx_msg_ready, .tx_msg_type, .tx_attr_mask, .tx_session_id, .tx_local_session,
      .tx_result_code, .tx_freq(), .tx_symrate(), .tx_power(), .tx_misc(), .tx_changeable(),
      .tx_caps(), .tx_udp_mtu(), .data_in_valid, .data_in_ready, .data_in, .data_out_valid,
      .data_out);
   tss_peer peer_u (.clk, .rx_msg_valid, .rx_msg_type, .rx_attr_mask, .rx_session_id,
      .rx_transport_stream_id, .rx_freq, .tx_msg_valid, .tx_msg_ready, .tx_msg_type,
      .tx_attr_mask, .tx_session_id, .tx_result_code);

   initial forever #10 clk = ~clk;

   // Hang guard, well above the whole sequence
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         close_out;
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   // One APB transfer; held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   // Waits for the next message the controller receives
   task wmsg(input logic [7:0] t);
      int n;
      n = peer_u.n_got;
      repeat (400) if (peer_u.n_got == n) @(negedge clk);
      chk(32'(peer_u.n_got - n), 32'h1);
      chk(32'(peer_u.got_type), 32'(t));
   endtask

   task push(input logic [7:0] d, input logic v);
      @(posedge clk);
      data_in_valid <= 1'b1;
      data_in <= d;
      @(posedge clk);
      data_in_valid <= 1'b0;
      data_in <= ~d;
      @(negedge clk);
      chk(32'(data_out_valid), 32'(v));
      if (v) chk(32'(data_out), 32'(d));
   endtask

   task t_regs;
      rchk(tss_pkg::OFS_LOCAL_SID, tss_pkg::RST_LOCAL_SID);
      rchk(tss_pkg::OFS_UDP_MTU, tss_pkg::RST_UDP_MTU);
      apb(1'b0, 12'h030, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
   endtask

   task t_hello;
      apb(1'b1, tss_pkg::OFS_TRANSPORT_STREAM_ID, 32'h0000_0021);
      apb(1'b1, tss_pkg::OFS_CTRL, 32'h1);
      wmsg(tss_pkg::MSG_HELLO);
   endtask

   task t_setup;
      peer_u.send(tss_pkg::MSG_ICRQ, tss_pkg::ICRQ_NEED, 16'h0021, 32'h0);
      wmsg(tss_pkg::MSG_ICRP);
      chk(32'(peer_u.got_mask), 32'(tss_pkg::ICRP_MASK));
      chk(peer_u.got_sid, 32'h0000_1234);
      chk(tx_local_session, tss_pkg::RST_LOCAL_SID);
      push(8'h3c, 1'b0);
      peer_u.send(tss_pkg::MSG_ICCN, 16'h0020, 16'h0021, 32'h0aa0_0000);
      wmsg(tss_pkg::MSG_ACK);
      rchk(tss_pkg::OFS_FREQ, 32'h0aa0_0000);
      push(8'ha5, 1'b1);
   endtask

   // Controller stalls while the update is offered
   task t_update;
      peer_u.stall = 1'b1;
      apb(1'b1, tss_pkg::OFS_POWER, 32'h0000_0123);
      repeat (8) @(negedge clk);
      chk(32'(tx_msg_valid), 32'h1);
      peer_u.stall = 1'b0;
      wmsg(tss_pkg::MSG_SLI);
      peer_u.send(tss_pkg::MSG_SLI, 16'h0040, 16'h0021, 32'h0);
      wmsg(tss_pkg::MSG_ACK);
      rchk(tss_pkg::OFS_POWER, 32'h0);
   endtask

   task t_teardown;
      apb(1'b1, tss_pkg::OFS_CTRL, 32'h3);
      wmsg(tss_pkg::MSG_CDN);
      peer_u.send(tss_pkg::MSG_ICRQ, 16'h4003, 16'h0021, 32'h0);
      wmsg(tss_pkg::MSG_CDN);
      chk(32'(peer_u.got_rc), 32'(tss_pkg::RC_MISSING_ATTR));
      peer_u.send(tss_pkg::MSG_ICRQ, tss_pkg::ICRQ_NEED, 16'h0022, 32'h0);
      wmsg(tss_pkg::MSG_CDN);
      chk(32'(peer_u.got_rc), 32'(tss_pkg::RC_BAD_TRANSPORT_STREAM_ID));
   endtask

   // Frequency made fixed, then the controller asks to change it
   task t_reject;
      apb(1'b1, tss_pkg::OFS_CHANGEABLE, 32'h0000_007e);
      peer_u.send(tss_pkg::MSG_ICRQ, tss_pkg::ICRQ_NEED, 16'h0021, 32'h0);
      wmsg(tss_pkg::MSG_ICRP);
      peer_u.send(tss_pkg::MSG_ICCN, 16'h0020, 16'h0021, 32'h0bb0_0000);
      wmsg(tss_pkg::MSG_CDN);
      chk(32'(peer_u.got_rc), 32'(tss_pkg::RC_PARAM_REJECT));
      push(8'h5a, 1'b0);
   endtask

   task t_stop;
      peer_u.send(tss_pkg::MSG_ICRQ, tss_pkg::ICRQ_NEED, 16'h0021, 32'h0);
      wmsg(tss_pkg::MSG_ICRP);
      peer_u.send(tss_pkg::MSG_CDN, tss_pkg::AT_RESULT, 16'h0021, 32'h0);
      wmsg(tss_pkg::MSG_ACK);
      rchk(tss_pkg::OFS_STATUS, {tss_pkg::RC_PARAM_REJECT, 16'h0001});
      peer_u.send(tss_pkg::MSG_STOPCCN, 16'h0000, 16'h0021, 32'h0);
      wmsg(tss_pkg::MSG_ACK);
      peer_u.send(tss_pkg::MSG_ICRQ, tss_pkg::ICRQ_NEED, 16'h0021, 32'h0);
      repeat (4) @(negedge clk);
      apb(1'b0, tss_pkg::OFS_STATUS, 32'h0);
      chk(rd & 32'h3, 32'h0);
      apb(1'b1, tss_pkg::OFS_CTRL, 32'h1);
      apb(1'b1, tss_pkg::OFS_CTRL, 32'h5);
      wmsg(tss_pkg::MSG_STOPCCN);
      chk(32'(peer_u.got_rc), 32'(tss_pkg::RC_ADMIN));
   endtask

   task close_out;
      if (miscompares == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_hello;
      t_setup;
      t_update;
      t_teardown;
      t_reject;
      t_stop;
      close_out;
   end
endmodule
